/* include/tsm_pkg.sv */
/*
 * tsm_pkg: constants and carrier types of the timer status monitor.
 * Assumes a 32-bit APB slave on the system clock; the counting engine
 * shares that clock and drives the event and state inputs directly.
 */
// Notes on behaviour
// - raw register shows events before masking
// - write one clears raw and masked bit
// - bits 17,16 hold B1,B0 threshold faults
// - bits 6..3 hold B1,B0,A1,A0 matches
// - bit 2 holds triangle up-phase expiry
// - bit 0 holds expiry; others reserved
// - monitor read returns live counter value
// - all-zero monitor write zeroes the counter only while not counting
// - start at or past length restarts from zero
// - status bit 3 shows count direction
// - status bits 2..0 show skip counter
// - mask bit one blocks interrupt request
// - masked status is raw gated by mask
package tsm_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_EVENT_MASK = 8'h40;
	localparam logic [7:0] OFS_MASKED_STATUS = 8'h44;
	localparam logic [7:0] OFS_RAW_STATUS = 8'h48;
	localparam logic [7:0] OFS_COUNT_MONITOR = 8'h50;
	localparam logic [7:0] OFS_RUN_STATUS = 8'h5C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_B1_FAULT = 17;
	localparam int POS_B0_FAULT = 16;
	localparam int POS_B1_MATCH = 6;
	localparam int POS_B0_MATCH = 5;
	localparam int POS_A1_MATCH = 4;
	localparam int POS_A0_MATCH = 3;
	localparam int POS_UPPHASE = 2;
	localparam int POS_PERIOD = 0;
	localparam int POS_DIRECTION = 3;
	localparam int SKIP_W = 3;

	// implemented event bits; everything else reads zero
	localparam logic [31:0] EVENT_BITS = 32'h0003_007D;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [31:0] RST_RAW = 32'h0000_0000;
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	localparam logic [31:0] MON_CLEAR_WORD = 32'h0000_0000;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic b1_fault;
		logic b0_fault;
		logic b1_match;
		logic b0_match;
		logic a1_match;
		logic a0_match;
		logic upphase_expire;
		logic period_expire;
	} tsm_events_t;

	typedef struct packed {
		logic count_direction;
		logic [SKIP_W-1:0] trigger_skip_count;
	} tsm_run_t;

endpackage

/* src/tsm_status_monitor.sv */
/*
 * tsm_status_monitor: raw and masked event status, event mask, count
 * monitor with zero request, and run status, behind an APB slave.
 * Assumes event inputs are one-cycle pulses and counter state comes
 * from the counting engine on the same clock; no synchronisers needed.
 */
`timescale 1ns/10ps
module tsm_status_monitor #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tsm_pkg::tsm_events_t events,
	input wire tsm_pkg::tsm_run_t run_state,
	input wire logic counting,
	input wire logic [CNT_W-1:0] count_value,
	input wire logic [CNT_W-1:0] period_length,
	output logic counter_zero,
	output logic event_irq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] raw;
		logic [31:0] mask;
		logic [31:0] rdata;
		logic slverr;
		logic zero_req;
		logic counting_d;
	} tsm_state_t;

	tsm_state_t st_r;
	tsm_state_t st_nxt;

	function automatic logic [31:0] tsm_event_word(input tsm_pkg::tsm_events_t ev);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[tsm_pkg::POS_B1_FAULT] = ev.b1_fault;
		w[tsm_pkg::POS_B0_FAULT] = ev.b0_fault;
		w[tsm_pkg::POS_B1_MATCH] = ev.b1_match;
		w[tsm_pkg::POS_B0_MATCH] = ev.b0_match;
		w[tsm_pkg::POS_A1_MATCH] = ev.a1_match;
		w[tsm_pkg::POS_A0_MATCH] = ev.a0_match;
		w[tsm_pkg::POS_UPPHASE] = ev.upphase_expire;
		w[tsm_pkg::POS_PERIOD] = ev.period_expire;
		return w;
	endfunction

	function automatic logic tsm_known(input logic [7:0] a);
		return a == tsm_pkg::OFS_EVENT_MASK || a == tsm_pkg::OFS_MASKED_STATUS ||
			a == tsm_pkg::OFS_RAW_STATUS || a == tsm_pkg::OFS_COUNT_MONITOR ||
			a == tsm_pkg::OFS_RUN_STATUS;
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic setup;
	logic wr_access;
	logic [31:0] ev_word;
	logic [31:0] masked;
	logic [31:0] status_word;
	logic start_clamp;
	logic mon_write_ok;

	assign setup = psel && !penable;
	// pready is always high, so every access phase completes at once
	assign wr_access = psel && penable && pwrite;
	assign ev_word = tsm_event_word(events);
	assign masked = st_r.raw & ~st_r.mask & tsm_pkg::EVENT_BITS;
	assign status_word = 32'({run_state.count_direction, run_state.trigger_skip_count});
	assign start_clamp = counting && !st_r.counting_d && (count_value >= period_length);
	// a non-zero write or one while counting is forbidden; drop and flag it
	assign mon_write_ok = !counting && pwdata == tsm_pkg::MON_CLEAR_WORD;

	always_comb begin
		st_nxt = st_r;
		st_nxt.counting_d = counting;
		st_nxt.zero_req = start_clamp;
		// set wins over a simultaneous clear; mask never gates the set
		st_nxt.raw = (st_r.raw & ~((wr_access && (paddr == tsm_pkg::OFS_RAW_STATUS ||
			paddr == tsm_pkg::OFS_MASKED_STATUS)) ? pwdata : 32'h0000_0000)) |
			(ev_word & tsm_pkg::EVENT_BITS);
		if (wr_access && paddr == tsm_pkg::OFS_EVENT_MASK) begin
			st_nxt.mask = pwdata & tsm_pkg::EVENT_BITS;
		end
		if (wr_access && paddr == tsm_pkg::OFS_COUNT_MONITOR && mon_write_ok) begin
			st_nxt.zero_req = 1'b1;
		end
		if (setup) begin
			st_nxt.slverr = !tsm_known(paddr) ||
				(pwrite && paddr == tsm_pkg::OFS_COUNT_MONITOR && !mon_write_ok) ||
				(pwrite && paddr == tsm_pkg::OFS_RUN_STATUS);
			case (paddr)
				tsm_pkg::OFS_EVENT_MASK: begin
					st_nxt.rdata = st_r.mask;
				end
				tsm_pkg::OFS_MASKED_STATUS: begin
					st_nxt.rdata = masked;
				end
				tsm_pkg::OFS_RAW_STATUS: begin
					st_nxt.rdata = st_r.raw & tsm_pkg::EVENT_BITS;
				end
				tsm_pkg::OFS_COUNT_MONITOR: begin
					st_nxt.rdata = 32'(count_value);
				end
				tsm_pkg::OFS_RUN_STATUS: begin
					st_nxt.rdata = status_word;
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{raw: tsm_pkg::RST_RAW, mask: tsm_pkg::RST_MASK, rdata: tsm_pkg::RST_RDATA,
				slverr: 1'b0, zero_req: 1'b0, counting_d: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = st_r.slverr && psel && penable;
	assign counter_zero = st_r.zero_req;
	assign event_irq = |masked;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_setup(logic [7:0] a);
		psel && !penable && paddr == a;
	endsequence

	sequence s_clear_write;
		psel && penable && pwrite && paddr == tsm_pkg::OFS_RAW_STATUS;
	endsequence

	chk_raw_sticky_set: assert property (@(posedge clk) disable iff (rst)
		events.period_expire |=> st_r.raw[tsm_pkg::POS_PERIOD] [*2] or
		(st_r.raw[tsm_pkg::POS_PERIOD] ##1 $past(wr_access)))
		else $error("expiry event not latched");

	chk_fault_latched: assert property (@(posedge clk) disable iff (rst)
		events.b1_fault |=> st_r.raw[tsm_pkg::POS_B1_FAULT])
		else $error("b1 fault not latched");

	chk_match_bits: assert property (@(posedge clk) disable iff (rst)
		events.a0_match && !events.b1_match |=> st_r.raw[tsm_pkg::POS_A0_MATCH])
		else $error("a0 match not latched");

	chk_w1c_clear: assert property (@(posedge clk) disable iff (rst)
		s_clear_write and pwdata[tsm_pkg::POS_UPPHASE] && !events.upphase_expire
		|=> !st_r.raw[tsm_pkg::POS_UPPHASE] && !masked[tsm_pkg::POS_UPPHASE])
		else $error("write one did not clear");

	chk_w0_keeps: assert property (@(posedge clk) disable iff (rst)
		s_clear_write and !pwdata[tsm_pkg::POS_PERIOD] && st_r.raw[tsm_pkg::POS_PERIOD]
		|=> st_r.raw[tsm_pkg::POS_PERIOD])
		else $error("write zero changed a bit");

	chk_raw_read: assert property (@(posedge clk) disable iff (rst)
		s_setup(tsm_pkg::OFS_RAW_STATUS) |=> prdata == ($past(st_r.raw) & tsm_pkg::EVENT_BITS)
		&& prdata[31:18] == 14'h0000)
		else $error("raw read mismatch");

	chk_mon_read: assert property (@(posedge clk) disable iff (rst)
		s_setup(tsm_pkg::OFS_COUNT_MONITOR) |=> prdata == 32'($past(count_value)))
		else $error("monitor read mismatch");

	chk_mon_zero: assert property (@(posedge clk) disable iff (rst)
		psel && penable && pwrite && paddr == tsm_pkg::OFS_COUNT_MONITOR && !counting
		&& pwdata == 32'h0000_0000 |=> counter_zero)
		else $error("zero write not passed on");

	chk_start_clamp: assert property (@(posedge clk) disable iff (rst)
		$rose(counting) && count_value >= period_length |=> counter_zero)
		else $error("start clamp missing");

	chk_status_read: assert property (@(posedge clk) disable iff (rst)
		s_setup(tsm_pkg::OFS_RUN_STATUS) |=> prdata[3] == $past(run_state.count_direction)
		&& prdata[2:0] == $past(run_state.trigger_skip_count) && prdata[31:4] == 28'h0000000)
		else $error("status read mismatch");

	chk_mask_gate: assert property (@(posedge clk) disable iff (rst)
		st_r.mask[tsm_pkg::POS_PERIOD] |-> !masked[tsm_pkg::POS_PERIOD])
		else $error("masked source reached status");

	chk_irq_unmasked: assert property (@(posedge clk) disable iff (rst)
		!st_r.mask[tsm_pkg::POS_PERIOD] && st_r.raw[tsm_pkg::POS_PERIOD] |-> event_irq)
		else $error("unmasked request did not reach output");

	chk_status_ro: assert property (@(posedge clk) disable iff (rst)
		psel && penable && pwrite && paddr == tsm_pkg::OFS_RUN_STATUS |-> pslverr)
		else $error("write to status not flagged");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		s_setup(tsm_pkg::OFS_RAW_STATUS) |=> prdata[15:7] == 9'h000 && !prdata[1])
		else $error("reserved raw bit read as one");

endmodule // tsm_status_monitor

/* tb/tsm_testbench.sv */
/*
 * testbench: self-checking bench for tsm_status_monitor over APB.
 * Assumes the hand-over timing: zero wait states, events as one-cycle pulses.
 */
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	tsm_pkg::tsm_events_t events = 8'h00;
	tsm_pkg::tsm_run_t run_state = 4'h0;
	logic counting = 1'b0;
	logic [15:0] count_value = 16'h0000;
	logic [15:0] period_length = 16'h0010;
	logic counter_zero;
	logic event_irq;
	int miscompares = 0;
	int cmp_count = 0;
	int pos [8] = '{0, 2, 3, 4, 5, 6, 16, 17};
	logic [31:0] rd;
	logic er;
	always #50 clk = ~clk;
	tsm_status_monitor #(.CNT_W(16)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .events(events), .run_state(run_state), .counting(counting),
		.count_value(count_value), .period_length(period_length), .counter_zero(counter_zero),
		.event_irq(event_irq));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one-cycle event pulse, then look after the edge that latched it
	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		events <= v;
		@(posedge clk);
		events <= 8'h00;
		#1;
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_events;
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			chk(event_irq, 1);
			apb(0, 8'h48, 0);
			chk(rd, 32'h1 << pos[i]);
			apb(1, 8'h48, 32'hFFFF_FFFF);
			apb(0, 8'h48, 0);
			chk(rd, 0);
		end
		pulse(8'h81);
		apb(1, 8'h48, 32'h0000_0001);
		apb(0, 8'h48, 0);
		chk(rd, 32'h0002_0000);
		apb(1, 8'h48, 32'h0002_0000);
		$display("events done");
	endtask
	task automatic t_mask;
		apb(1, 8'h40, 32'h0003_007D);
		pulse(8'h01);
		chk(event_irq, 0);
		apb(0, 8'h44, 0);
		chk(rd, 0);
		apb(0, 8'h48, 0);
		chk(rd, 1);
		apb(1, 8'h48, 1);
		apb(1, 8'h40, 0);
		$display("mask done");
	endtask
	task automatic t_monitor;
		count_value <= 16'h1234;
		apb(0, 8'h50, 0);
		chk(rd, 32'h0000_1234);
		apb(1, 8'h50, 32'h0000_0005);
		chk(er, 1);
		#1 chk(counter_zero, 0);
		apb(1, 8'h50, 0);
		#1 chk(counter_zero, 1);
		@(posedge clk);
		#1 chk(counter_zero, 0);
		@(posedge clk);
		counting <= 1'b1;
		@(posedge clk);
		#1 chk(counter_zero, 1);
		apb(1, 8'h50, 0);
		chk(er, 1);
		@(posedge clk);
		counting <= 1'b0;
		count_value <= 16'h0003;
		@(posedge clk);
		counting <= 1'b1;
		@(posedge clk);
		#1 chk(counter_zero, 0);
		$display("monitor done");
	endtask
	task automatic t_status;
		run_state <= 4'hD;
		apb(0, 8'h5C, 0);
		chk(rd, 32'h0000_000D);
		run_state <= 4'h2;
		apb(1, 8'h5C, 32'hFFFF_FFFF);
		chk(er, 1);
		apb(0, 8'h5C, 0);
		chk(rd, 32'h0000_0002);
		apb(0, 8'h4C, 0);
		chk(rd, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		chk(32'(pready), 32'h0000_0001);
		$display("status done");
	endtask
	initial begin
		#(100 * 5000);
		miscompares++;
		results;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		apb(0, 8'h48, 0);
		chk(rd, 0);
		apb(0, 8'h5C, 0);
		chk(rd, 0);
		t_events;
		t_mask;
		t_monitor;
		t_status;
		results;
	end
endmodule // testbench
